// File: verilog/sacc_consts.svh
`ifndef SACC_CONSTS_SVH
`define SACC_CONSTS_SVH

// Byte offsets of the register words.
`define SACC_OFF_CTRL_A 5'h00
`define SACC_OFF_CTRL_B 5'h04
`define SACC_OFF_CHREF 5'h08
`define SACC_OFF_RES_LO 5'h0C
`define SACC_OFF_RES_HI 5'h10
`define SACC_OFF_TFLAG 5'h14

// Field positions in converter_control_a.
`define SACC_A_EN 7
`define SACC_A_START 6
`define SACC_A_ATE 5
`define SACC_A_DONE 4

// Field positions in channel_reference_control.
`define SACC_C_REF_HI 7
`define SACC_C_REF_LO 6
`define SACC_C_LADJ 5

// Reset values.
`define SACC_RST_PS 3'h0
`define SACC_RST_TS 3'h0
`define SACC_RST_MUX 3'h0
`define SACC_RST_REF 2'h0

// Conversion timing; the _HALF values count half converter clock cycles, the sync depth CPU cycles.
`define SACC_NORM_CYC 13
`define SACC_FIRST_CYC 25
`define SACC_NORM_HALF (2 * `SACC_NORM_CYC)
`define SACC_FIRST_HALF (2 * `SACC_FIRST_CYC)
`define SACC_AUTO_HALF 27
`define SACC_SH_NORM_HALF 3
`define SACC_SH_FIRST_HALF 27
`define SACC_SH_AUTO_HALF 4
`define SACC_TRIG_SYNC 3

`endif

// File: verilog/sacc_pkg.sv
package sacc_pkg;
    typedef enum logic [1:0] {
        SACC_IDLE = 2'b00,
        SACC_WAIT = 2'b01,
        SACC_CONV = 2'b10
    } sacc_state_t;
endpackage

// File: verilog/sacc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sacc_consts.svh"

// Overview of operation
// - Writing one to the start bit begins a single conversion.
// - Start bit stays set while converting and hardware clears it on completion unless free running.
// - Channel changes during a conversion act only from its last converter cycle.
// - Auto-trigger rising edge resets the prescaler and starts a conversion.
// - Trigger still high at completion, or edges during conversion, start nothing.
// - Trigger flags set even when masked; software clears them before re-trigger.
// - Done flag as trigger gives continuous conversion; software starts the first.
// - Reading the low byte locks results until the high byte is read.
// - Completion flag still sets when a locked result is discarded.
// - Result right-aligned by default, left-aligned when left-adjust is set.
// - Reference and channel reach the converter only while enabled.
// - Prescaler runs while enabled and is held in reset while disabled.
// - Software start begins at the next converter clock rising edge.
// - Normal conversion lasts 13 converter cycles, first one 25.
// - Sample-and-hold at 1.5 cycles normally, 13.5 on the first conversion.
// - Completion writes result, sets done flag, clears start in single mode.
// - Auto-trigger sampling two cycles after edge, plus three CPU sync cycles.
// - Free running restarts at once after completion with start bit held.
// - Start bit works under auto-trigger and reads one during any conversion.
// - Selections pass a holding register frozen during conversion until its last cycle.
// - Auto-triggered conversion lasts 13.5 cycles, sample-and-hold at 2.
module sacc_top
    import sacc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:1] trig_event,
    input wire logic [9:0] analog_result,
    output logic analog_enable,
    output logic sample_hold,
    output logic [2:0] channel_out,
    output logic [1:0] reference_out
);

    // Half period of the converter clock in CPU cycles; the smallest divider is two.
    function automatic logic [6:0] half_period(input logic [2:0] ps);
        half_period = (ps <= 3'h1) ? 7'h01 : 7'(7'h01 << (ps - 3'h1));
    endfunction

    function automatic logic [5:0] conv_len(input logic first, input logic auto_c);
        conv_len = first ? 6'(`SACC_FIRST_HALF) : (auto_c ? 6'(`SACC_AUTO_HALF) : 6'(`SACC_NORM_HALF));
    endfunction

    function automatic logic [5:0] sh_point(input logic first, input logic auto_c);
        sh_point = first ? 6'(`SACC_SH_FIRST_HALF) : (auto_c ? 6'(`SACC_SH_AUTO_HALF) : 6'(`SACC_SH_NORM_HALF));
    endfunction

    function automatic logic [15:0] align(input logic [9:0] r, input logic ladj);
        align = ladj ? {r, 6'h00} : {6'h00, r};
    endfunction

    sacc_state_t st_q, st_d;
    logic en_q, en_d, start_q, start_d, ate_q, ate_d, done_q, done_d;
    logic [2:0] ps_q, ps_d, ts_q, ts_d, mux_q, mux_d, hmux_q, hmux_d;
    logic [1:0] ref_q, ref_d, href_q, href_d;
    logic ladj_q, ladj_d, lock_q, lock_d;
    logic [9:0] res_q, res_d;
    logic [7:1] tflag_q, tflag_d;
    logic trig_prev_q, trig_prev_d;
    logic [`SACC_TRIG_SYNC-1:0] sync_q, sync_d;
    logic [6:0] presc_q, presc_d;
    logic phase_q, phase_d, first_q, first_d, auto_q, auto_d, sh_q, sh_d;
    logic [5:0] hcnt_q, hcnt_d;
    logic wr_q, wr_d, rdy_q;
    logic [4:0] waddr_q, waddr_d;
    logic [31:0] rdata_q, rdata_d;

    logic tick, rise, trig_sig, trig_edge, free_run, done_ev, track, addr_ok, rd_lo, rd_hi;
    logic [15:0] al;

    assign tick = (presc_q == half_period(ps_q) - 7'h01);
    assign rise = tick && !phase_q;
    assign free_run = ate_q && (ts_q == 3'h0);
    assign trig_sig = (ts_q == 3'h0) ? done_q : tflag_q[ts_q];
    assign done_ev = ce && (st_q == SACC_CONV) && tick && (hcnt_q == conv_len(first_q, auto_q) - 6'h01);
    assign track = (st_q != SACC_CONV) || (hcnt_q >= conv_len(first_q, auto_q) - 6'h02);
    assign addr_ok = hsel && hready && htrans[1] && ce;
    assign rd_lo = addr_ok && !hwrite && (haddr[4:0] == `SACC_OFF_RES_LO);
    assign rd_hi = addr_ok && !hwrite && (haddr[4:0] == `SACC_OFF_RES_HI);
    assign al = align(res_q, ladj_q);
    // Edge seen only outside a conversion; a level held at completion is no new edge.
    assign trig_edge = ate_q && (ts_q != 3'h0) && trig_sig && !trig_prev_q;

    always_comb begin
        st_d = st_q;
        en_d = en_q;
        start_d = start_q;
        ate_d = ate_q;
        done_d = done_q;
        ps_d = ps_q;
        ts_d = ts_q;
        mux_d = mux_q;
        ref_d = ref_q;
        ladj_d = ladj_q;
        hmux_d = hmux_q;
        href_d = href_q;
        lock_d = lock_q;
        res_d = res_q;
        tflag_d = tflag_q;
        trig_prev_d = trig_sig;
        sync_d = {sync_q[`SACC_TRIG_SYNC-2:0], 1'b0};
        presc_d = tick ? 7'h00 : presc_q + 7'h01;
        phase_d = tick ? !phase_q : phase_q;
        first_d = first_q;
        auto_d = auto_q;
        sh_d = 1'b0;
        hcnt_d = hcnt_q;
        wr_d = addr_ok && hwrite;
        waddr_d = haddr[4:0];
        rdata_d = 32'h0000_0000;
        if (addr_ok && !hwrite) begin
            unique case (haddr[4:0])
                `SACC_OFF_CTRL_A: rdata_d = {24'h000000, en_q, start_q, ate_q, done_q, 1'b0, ps_q};
                `SACC_OFF_CTRL_B: rdata_d = {29'h00000000, ts_q};
                `SACC_OFF_CHREF: rdata_d = {24'h000000, ref_q, ladj_q, 2'b00, mux_q};
                `SACC_OFF_RES_LO: rdata_d = {24'h000000, al[7:0]};
                `SACC_OFF_RES_HI: rdata_d = {24'h000000, al[15:8]};
                `SACC_OFF_TFLAG: rdata_d = {24'h000000, tflag_q, 1'b0};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        if (rd_lo) begin
            lock_d = 1'b1;
        end
        if (rd_hi) begin
            lock_d = 1'b0;
        end
        // Data phase of a write; clearing writes come before hardware sets so the set wins.
        if (wr_q) begin
            unique case (waddr_q)
                `SACC_OFF_CTRL_A: begin
                    en_d = hwdata[`SACC_A_EN];
                    ate_d = hwdata[`SACC_A_ATE];
                    ps_d = hwdata[2:0];
                    if (hwdata[`SACC_A_DONE]) begin
                        done_d = 1'b0;
                    end
                    if (hwdata[`SACC_A_START] && hwdata[`SACC_A_EN] && st_q == SACC_IDLE) begin
                        start_d = 1'b1;
                        st_d = SACC_WAIT;
                    end
                end
                `SACC_OFF_CTRL_B: ts_d = hwdata[2:0];
                `SACC_OFF_CHREF: begin
                    ref_d = hwdata[`SACC_C_REF_HI:`SACC_C_REF_LO];
                    ladj_d = hwdata[`SACC_C_LADJ];
                    mux_d = hwdata[2:0];
                end
                `SACC_OFF_TFLAG: tflag_d = tflag_q & ~hwdata[7:1];
                default: begin
                end
            endcase
        end
        tflag_d = tflag_d | trig_event;
        if (en_d && !en_q) begin
            first_d = 1'b1;
        end
        if (track && en_q) begin
            hmux_d = mux_q;
            href_d = ref_q;
        end
        if (trig_edge && st_q == SACC_IDLE) begin
            sync_d[0] = 1'b1;
        end
        unique case (st_q)
            SACC_IDLE: begin
                if (sync_q[`SACC_TRIG_SYNC-1] && ate_q) begin
                    presc_d = 7'h00;
                    phase_d = 1'b1;
                    hcnt_d = 6'h00;
                    auto_d = 1'b1;
                    start_d = 1'b1;
                    st_d = SACC_CONV;
                end
            end
            SACC_WAIT: begin
                if (rise) begin
                    hcnt_d = 6'h00;
                    auto_d = 1'b0;
                    st_d = SACC_CONV;
                end
            end
            SACC_CONV: begin
                if (tick) begin
                    hcnt_d = hcnt_q + 6'h01;
                    if (hcnt_q == sh_point(first_q, auto_q) - 6'h01) begin
                        sh_d = 1'b1;
                    end
                end
                if (done_ev) begin
                    done_d = 1'b1;
                    first_d = 1'b0;
                    if (!lock_q) begin
                        res_d = analog_result;
                    end
                    if (free_run) begin
                        hcnt_d = 6'h00;
                        auto_d = 1'b0;
                    end else begin
                        start_d = 1'b0;
                        st_d = SACC_IDLE;
                    end
                end
            end
            default: st_d = SACC_IDLE;
        endcase
        if (!en_d) begin
            presc_d = 7'h00;
            phase_d = 1'b0;
            st_d = SACC_IDLE;
            start_d = 1'b0;
            sync_d = '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= SACC_IDLE;
            en_q <= 1'b0;
            start_q <= 1'b0;
            ate_q <= 1'b0;
            done_q <= 1'b0;
            ps_q <= `SACC_RST_PS;
            ts_q <= `SACC_RST_TS;
            mux_q <= `SACC_RST_MUX;
            ref_q <= `SACC_RST_REF;
            ladj_q <= 1'b0;
            hmux_q <= `SACC_RST_MUX;
            href_q <= `SACC_RST_REF;
            lock_q <= 1'b0;
            res_q <= 10'h000;
            tflag_q <= 7'h00;
            trig_prev_q <= 1'b0;
            sync_q <= '0;
            presc_q <= 7'h00;
            phase_q <= 1'b0;
            first_q <= 1'b0;
            auto_q <= 1'b0;
            sh_q <= 1'b0;
            hcnt_q <= 6'h00;
            wr_q <= 1'b0;
            waddr_q <= 5'h00;
            rdata_q <= 32'h0000_0000;
            rdy_q <= 1'b0;
        end else if (ce) begin
            st_q <= st_d;
            en_q <= en_d;
            start_q <= start_d;
            ate_q <= ate_d;
            done_q <= done_d;
            ps_q <= ps_d;
            ts_q <= ts_d;
            mux_q <= mux_d;
            ref_q <= ref_d;
            ladj_q <= ladj_d;
            hmux_q <= hmux_d;
            href_q <= href_d;
            lock_q <= lock_d;
            res_q <= res_d;
            tflag_q <= tflag_d;
            trig_prev_q <= trig_prev_d;
            sync_q <= sync_d;
            presc_q <= presc_d;
            phase_q <= phase_d;
            first_q <= first_d;
            auto_q <= auto_d;
            sh_q <= sh_d;
            hcnt_q <= hcnt_d;
            wr_q <= wr_d;
            waddr_q <= waddr_d;
            rdata_q <= rdata_d;
            rdy_q <= 1'b1;
        end
    end

    // The slave never inserts wait states, so hreadyout is low only from reset until the first cycle with ce high.
    assign hreadyout = rdy_q;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    assign analog_enable = en_q;
    assign sample_hold = sh_q;
    assign channel_out = hmux_q;
    assign reference_out = href_q;

    a_busy_bit: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q == SACC_CONV |-> start_q) else $error("start bit low during conversion");
    a_done_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        done_ev |=> done_q) else $error("done flag not set at completion");
    a_single_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        done_ev && !free_run |=> !start_q && st_q == SACC_IDLE) else $error("start bit not cleared");
    a_free_restart: assert property (@(posedge hclk) disable iff (!hresetn)
        done_ev && free_run && en_q |=> start_q && st_q == SACC_CONV && hcnt_q == 6'h00)
        else $error("free run did not restart");
    a_lock_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        lock_q |=> $stable(res_q)) else $error("result changed while locked");
    a_presc_off: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && !en_q && !en_d |=> presc_q == 7'h00 && !phase_q) else $error("prescaler ran while disabled");
    a_hold_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
        !track && ce |=> $stable(hmux_q) && $stable(href_q)) else $error("selection moved mid conversion");
    a_sample_norm: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && st_q == SACC_CONV && tick && !first_q && !auto_q && hcnt_q == 6'h02 |=> sample_hold)
        else $error("normal sample point missed");
    a_wait_edge: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q == SACC_WAIT && ce && !rise && en_d |=> st_q == SACC_WAIT) else $error("start before clock edge");

    // Timing checks use literal counts so that a slip in the length functions is caught.
    a_wait_start: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q == SACC_WAIT && ce && rise && en_d |=> st_q == SACC_CONV && hcnt_q == 6'h00)
        else $error("conversion did not begin on clock edge");
    a_conv_length: assert property (@(posedge hclk) disable iff (!hresetn)
        done_ev |-> (first_q ? hcnt_q == 6'h31 : (auto_q ? hcnt_q == 6'h1A : hcnt_q == 6'h19)))
        else $error("conversion length wrong");
    a_sample_first: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && st_q == SACC_CONV && tick && first_q && hcnt_q == 6'h1A |=> sample_hold)
        else $error("first sample point missed");
    a_sample_auto: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && st_q == SACC_CONV && tick && !first_q && auto_q && hcnt_q == 6'h03 |=> sample_hold)
        else $error("auto sample point missed");
    a_en_first: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && en_d && !en_q |=> first_q)
        else $error("first conversion not marked");

    // Trigger path: the three sync stages must start exactly one conversion per edge.
    a_auto_start: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && en_d && ate_q && st_q == SACC_IDLE && sync_q[`SACC_TRIG_SYNC-1] |=>
        st_q == SACC_CONV && start_q && presc_q == 7'h00)
        else $error("trigger did not start conversion");
    a_edge_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && st_q == SACC_CONV |=> !sync_q[0])
        else $error("trigger edge taken mid conversion");
    a_tflag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        ce |=> (tflag_q & $past(trig_event)) == $past(trig_event))
        else $error("trigger flag not set");

    // Result and selection paths.
    a_lock_set: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_lo |=> lock_q)
        else $error("low byte read did not lock");
    a_result_load: assert property (@(posedge hclk) disable iff (!hresetn)
        done_ev && !lock_q |=> res_q == $past(analog_result))
        else $error("result not written at completion");
    a_hold_off: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && !en_q |=> $stable(hmux_q) && $stable(href_q))
        else $error("selection applied while disabled");
    a_off_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && !en_d |=> !start_q && st_q == SACC_IDLE)
        else $error("converter active while disabled");

endmodule
`default_nettype wire

// File: testbench/sacc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module sacc_analog_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic analog_enable,
    input wire logic sample_hold,
    input wire logic [2:0] channel_out,
    input wire logic [1:0] reference_out,
    output logic [9:0] analog_result
);
    logic [9:0] held_q;
    logic [4:0] count_q;
    // A core that is off shows the inverse of its last code, so a stale read never matches.
    assign analog_result = analog_enable ? held_q : ~held_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            held_q <= 10'h000;
            count_q <= 5'h00;
        end else if (sample_hold) begin
            held_q <= {channel_out, reference_out, count_q};
            count_q <= count_q + 5'h01;
        end
    end
endmodule
`default_nettype wire

// File: testbench/sar_adc_conversion_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sacc_consts.svh"
module sar_adc_conversion_control_tb;
    localparam logic [31:0] EN = 32'h00000080;
    localparam logic [31:0] ST = 32'h00000040;
    localparam logic [31:0] AT = 32'h00000020;
    localparam logic [31:0] DN = 32'h00000010;
    logic hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, analog_enable, sample_hold;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, reference_out, rf;
    logic [2:0] hsize, channel_out, ch, ps;
    logic [7:1] trig_event;
    logic [9:0] analog_result;
    int err_total, check_count, cyc, sh_n, h, t0, n0, ts, ladj;
    sacc_top i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .trig_event(trig_event), .analog_result(analog_result),
        .analog_enable(analog_enable), .sample_hold(sample_hold), .channel_out(channel_out),
        .reference_out(reference_out));
    sacc_analog_model i_core (.hclk(hclk), .hresetn(hresetn), .analog_enable(analog_enable),
        .sample_hold(sample_hold), .channel_out(channel_out), .reference_out(reference_out),
        .analog_result(analog_result));
    always #5 hclk = ~hclk;
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (sample_hold === 1'b1)
            sh_n <= sh_n + 1;
        if (cyc == 30000) begin
            err_total++;
            $display("ERROR timeout expected end seen hang");
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rng(input string nm, input int lo, input int hi, input int g);
        check_count++;
        if (g < lo || g > hi) begin
            err_total++;
            $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    // Called just after a rising edge; returns on the edge that ends the data phase.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {27'h0, a};
        hwrite <= w;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do begin bus(1'b0, `SACC_OFF_CTRL_A, 0); n++; end while (rd[6] !== 1'b0 && n < 2000);
    endtask
    function automatic logic [9:0] ev(input int k);
        return {ch, rf, k[4:0]};
    endfunction
    task automatic res_chk(input logic [9:0] e);
        bus(1'b0, `SACC_OFF_RES_LO, 0);
        chk("result low", ladj ? {24'h0, e[1:0], 6'h0} : {24'h0, e[7:0]}, rd);
        bus(1'b0, `SACC_OFF_RES_HI, 0);
        chk("result high", ladj ? {24'h0, e[9:2]} : {30'h0, e[9:8]}, rd);
    endtask
    task automatic pulse(input int s);
        trig_event <= 7'h01 << (s - 1);
        @(posedge hclk);
        trig_event <= 7'h00;
        @(posedge hclk);
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge hclk);
    endtask
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        trig_event = 7'h00;
        void'($urandom(32'h90AF));
        idle(6);
        hresetn <= 1'b1;
        idle(1);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 5'(i * 4), 0);
            chk("reset value", 32'h0, rd);
        end
        chk("response", 32'h0, 32'(hresp));
        bus(1'b1, 5'h18, 32'hFF);
        bus(1'b0, 5'h18, 0);
        chk("unmapped", 32'h0, rd);
        $display("test registers done");
        ch = 3'($urandom_range(7, 1));
        rf = 2'($urandom_range(3, 0));
        ps = 3'($urandom_range(2, 0));
        h = (ps < 2) ? 1 : (1 << (ps - 1));
        bus(1'b1, `SACC_OFF_CHREF, {24'h0, rf, 6'h0} | 32'(ch));
        chk("channel while off", 32'h0, 32'(channel_out));
        bus(1'b1, `SACC_OFF_CTRL_A, EN | 32'(ps));
        idle(2);
        chk("channel when on", 32'(ch), 32'(channel_out));
        chk("core enable", 32'h1, 32'(analog_enable));
        for (int k = 0; k < 2; k++) begin
            ladj = k;
            n0 = sh_n;
            bus(1'b1, `SACC_OFF_CHREF, {24'h0, rf, 1'(k), 5'h0} | 32'(ch));
            bus(1'b1, `SACC_OFF_CTRL_A, EN | ST | 32'(ps));
            t0 = cyc;
            bus(1'b0, `SACC_OFF_CTRL_A, 0);
            chk("busy bit", ST, rd & ST);
            wait_idle();
            rng("length", (k ? 26 : 50) * h, (k ? 28 : 52) * h + 8, cyc - t0);
            chk("done flag", DN, rd & DN);
            chk("samples", 32'(n0 + 1), 32'(sh_n));
            res_chk(ev(sh_n - 1));
        end
        bus(1'b1, `SACC_OFF_CTRL_A, EN | DN | 32'(ps));
        bus(1'b0, `SACC_OFF_RES_LO, 0);
        n0 = sh_n;
        bus(1'b1, `SACC_OFF_CTRL_A, EN | ST | 32'(ps));
        wait_idle();
        chk("done when locked", DN, rd & DN);
        res_chk(ev(n0 - 1));
        n0 = sh_n;
        bus(1'b1, `SACC_OFF_CTRL_A, EN | ST | 32'(ps));
        idle(6 * h + 2);
        bus(1'b1, `SACC_OFF_CHREF, {24'h0, rf, 1'(ladj), 5'h0} | 32'(ch ^ 3'h5));
        idle(1);
        chk("held channel", 32'(ch), 32'(channel_out));
        wait_idle();
        res_chk(ev(n0));
        chk("new channel", 32'(ch ^ 3'h5), 32'(channel_out));
        ch = ch ^ 3'h5;
        $display("test single done");
        ts = $urandom_range(7, 1);
        bus(1'b1, `SACC_OFF_CTRL_B, 32'(ts));
        bus(1'b1, `SACC_OFF_TFLAG, 32'hFE);
        bus(1'b1, `SACC_OFF_CTRL_A, EN | AT | DN | 32'(ps));
        n0 = sh_n;
        pulse(ts % 7 + 1);
        idle(40 * h);
        chk("other source", 32'(n0), 32'(sh_n));
        t0 = cyc;
        pulse(ts);
        while (sh_n == n0 && cyc - t0 < 200)
            idle(1);
        rng("trigger to sample", 4 * h + 2, 4 * h + 9, cyc - t0);
        bus(1'b0, `SACC_OFF_CTRL_A, 0);
        chk("busy on trigger", ST, rd & ST);
        pulse(ts);
        wait_idle();
        idle(40 * h);
        chk("one sample", 32'(n0 + 1), 32'(sh_n));
        bus(1'b0, `SACC_OFF_TFLAG, 0);
        chk("flag set", 32'h1 << ts, rd & (32'h1 << ts));
        pulse(ts);
        idle(40 * h);
        chk("flag blocks", 32'(n0 + 1), 32'(sh_n));
        bus(1'b1, `SACC_OFF_TFLAG, 32'h1 << ts);
        pulse(ts);
        idle(8 * h);
        wait_idle();
        chk("after clear", 32'(n0 + 2), 32'(sh_n));
        res_chk(ev(n0 + 1));
        bus(1'b1, `SACC_OFF_CTRL_A, EN | AT | ST | 32'(ps));
        wait_idle();
        chk("start under trigger", 32'(n0 + 3), 32'(sh_n));
        $display("test trigger done");
        bus(1'b1, `SACC_OFF_CTRL_B, 0);
        n0 = sh_n;
        bus(1'b1, `SACC_OFF_CTRL_A, EN | AT | ST | 32'(ps));
        for (int i = 0; i < 50; i++) begin
            bus(1'b0, `SACC_OFF_CTRL_A, 0);
            idle(2 * h);
            chk("free run busy", ST, rd & ST);
        end
        rng("free run count", (100 + 100 * h) / (27 * h) - 1, (100 + 100 * h) / (26 * h) + 1, sh_n - n0);
        bus(1'b1, `SACC_OFF_CTRL_A, EN | 32'(ps));
        wait_idle();
        n0 = sh_n;
        idle(60 * h);
        chk("stopped", 32'(n0), 32'(sh_n));
        bus(1'b1, `SACC_OFF_CTRL_A, 0);
        bus(1'b1, `SACC_OFF_CHREF, 32'(ch ^ 3'h7));
        bus(1'b1, `SACC_OFF_CTRL_A, ST);
        idle(4);
        chk("core off", 32'h0, 32'(analog_enable));
        chk("channel kept", 32'(ch), 32'(channel_out));
        bus(1'b0, `SACC_OFF_CTRL_A, 0);
        chk("no start when off", 32'h0, rd & ST);
        bus(1'b1, `SACC_OFF_CTRL_A, EN | 32'(ps));
        bus(1'b1, `SACC_OFF_CTRL_A, EN | ST | 32'(ps));
        n0 = sh_n;
        ce <= 1'b0;
        idle(60 * h + 20);
        chk("frozen samples", 32'(n0), 32'(sh_n));
        ce <= 1'b1;
        wait_idle();
        chk("after freeze", 32'(n0 + 1), 32'(sh_n));
        $display("test disable done");
        conclude();
    end
endmodule
`default_nettype wire
